// >>> verilog/tcit_pkg.sv
// constants for the timer clock selection, prescalers, interval timer and trims
// assumes one 100 MHz system clock and an APB slave with byte addresses 4x index
//
// Behaviour
// - interval source select: 00 fast osc, 01 external, 10 slow osc, 11 capture tick
// - interval divider codes 00..11 divide the selected source by 1, 2, 3, 4
// - capture divider codes 00..11 divide the selected source by 2, 4, 6, 8
// - capture source select: 00 fast osc, 01 external, 10 slow osc, 11 off
// - external source is crystal output when crystal enabled, else clock input pin
// - interval timer is a 12-bit down counter on interval ticks with reload value
// - the tick after the counter reaches zero loads the reload value instead
// - an interrupt request to the CPU is raised on every reload
// - reload value stays read/write while running; software avoids split-write reloads
// - the reload register holds what is copied into the counter at terminal count
// - 1024 us tick counts capture ticks, nominal 4 MHz, scales with that clock
// - source change needs the old clock running; stopped capture cannot leave
// - trim registers hold boot calibration values written by software after boot
// - fast osc trim: three offset bits 7.5/15/30 kHz and a five-bit gain field
// - crystal trim mode bit: 0 oscillator mode, 1 fixed maximum bias test mode
// - slow osc low-power bit set selects low power mode, clear selects normal
// - four-bit frequency trim field adjusts the slow oscillator frequency
// - crystal enable starts crystal, routes it as external clock, releases shared pins

package tcit_pkg;

	localparam int TCIT_ADDR_W = 8;
	localparam int TCIT_DATA_W = 32;

	// register indices; the bus address is four times the index
	localparam int TCIT_IDX_TIMER_CFG   = 'h31;
	localparam int TCIT_IDX_PIN_CFG     = 'h32;
	localparam int TCIT_IDX_FAST_TRIM   = 'h34;
	localparam int TCIT_IDX_XTAL_TRIM   = 'h35;
	localparam int TCIT_IDX_SLOW_TRIM   = 'h36;
	localparam int TCIT_IDX_RELOAD_LO   = 'h3a;
	localparam int TCIT_IDX_RELOAD_HI   = 'h3b;
	localparam int TCIT_IDX_COUNT_LO    = 'h3c;
	localparam int TCIT_IDX_COUNT_HI    = 'h3d;

	localparam logic [7:0] TCIT_ADDR_TIMER_CFG = 8'(TCIT_IDX_TIMER_CFG * 4);
	localparam logic [7:0] TCIT_ADDR_PIN_CFG   = 8'(TCIT_IDX_PIN_CFG * 4);
	localparam logic [7:0] TCIT_ADDR_FAST_TRIM = 8'(TCIT_IDX_FAST_TRIM * 4);
	localparam logic [7:0] TCIT_ADDR_XTAL_TRIM = 8'(TCIT_IDX_XTAL_TRIM * 4);
	localparam logic [7:0] TCIT_ADDR_SLOW_TRIM = 8'(TCIT_IDX_SLOW_TRIM * 4);
	localparam logic [7:0] TCIT_ADDR_RELOAD_LO = 8'(TCIT_IDX_RELOAD_LO * 4);
	localparam logic [7:0] TCIT_ADDR_RELOAD_HI = 8'(TCIT_IDX_RELOAD_HI * 4);
	localparam logic [7:0] TCIT_ADDR_COUNT_LO  = 8'(TCIT_IDX_COUNT_LO * 4);
	localparam logic [7:0] TCIT_ADDR_COUNT_HI  = 8'(TCIT_IDX_COUNT_HI * 4);

	// timer_clock_config field positions
	localparam int TCIT_INT_SEL_LSB = 0;
	localparam int TCIT_INT_DIV_LSB = 2;
	localparam int TCIT_CAP_SEL_LSB = 4;
	localparam int TCIT_CAP_DIV_LSB = 6;
	localparam logic [7:0] TCIT_TIMER_CFG_RESET = 8'h8f;

	// clock_pin_config
	localparam int TCIT_XTAL_EN_BIT = 3;
	localparam logic [7:0] TCIT_PIN_CFG_MASK = 8'h08;

	// trims: writable bits; reserved bits read zero
	localparam logic [7:0] TCIT_FAST_TRIM_MASK = 8'hff;
	localparam logic [7:0] TCIT_XTAL_TRIM_MASK = 8'h1d;
	localparam logic [7:0] TCIT_SLOW_TRIM_MASK = 8'hbf;
	localparam logic [7:0] TCIT_TRIM_RESET     = 8'h00;
	localparam int TCIT_FAST_OFS_LSB  = 5;
	localparam int TCIT_FAST_GAIN_LSB = 0;
	localparam int TCIT_XTAL_GM_LSB   = 2;
	localparam int TCIT_XTAL_MODE_BIT = 0;
	localparam int TCIT_SLOW_LP_BIT   = 7;
	localparam int TCIT_SLOW_BIAS_LSB = 4;
	localparam int TCIT_SLOW_FREQ_LSB = 0;

	// source select codes, shared by both timer clocks
	localparam logic [1:0] TCIT_SRC_FAST  = 2'h0;
	localparam logic [1:0] TCIT_SRC_EXT   = 2'h1;
	localparam logic [1:0] TCIT_SRC_SLOW  = 2'h2;
	localparam logic [1:0] TCIT_SRC_OTHER = 2'h3;

	// bit positions in the synchronised oscillator vector
	localparam int TCIT_PIN_FAST = 0;
	localparam int TCIT_PIN_EXT  = 1;
	localparam int TCIT_PIN_XTAL = 2;
	localparam int TCIT_PIN_SLOW = 3;
	localparam int TCIT_NUM_SRC  = 4;

	// interval timer and reload
	localparam int TCIT_CNT_W     = 12;
	localparam int TCIT_RELOAD_HI_W = TCIT_CNT_W - 8;

	// 1024 us interval from capture ticks at a nominal 4 MHz
	localparam int TCIT_MS_INTERVAL_US = 1024;
	localparam int TCIT_CAP_NOMINAL_MHZ = 4;
	localparam int TCIT_MS_TICKS = TCIT_MS_INTERVAL_US * TCIT_CAP_NOMINAL_MHZ;
	localparam logic [11:0] TCIT_MS_LAST = 12'(TCIT_MS_TICKS - 1);

endpackage

// >>> verilog/tcit_timer_clock.sv
// timer clock selection, prescalers, 12-bit interval timer and oscillator trims
// assumes oscillator clocks arrive as asynchronous pins, sampled by sys_clk;
// sys_clk must run faster than twice the fastest oscillator for edges to be seen
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ns

module tcit_timer_clock
	import tcit_pkg::*;
(
	input  wire logic                   sys_clk,
	input  wire logic                   arst_n,
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [TCIT_ADDR_W-1:0] paddr,
	input  wire logic [TCIT_DATA_W-1:0] pwdata,
	output logic      [TCIT_DATA_W-1:0] prdata,
	output logic                        pready,
	output logic                        pslverr,
	input  wire logic                   fastOscPin,
	input  wire logic                   slowOscPin,
	input  wire logic                   crystalOscPin,
	input  wire logic                   extClockInputPin,
	input  wire logic [1:0]             gpioDriveReq,
	output logic      [1:0]             sharedPinOutEnable,
	output logic                        crystalOscEnable,
	output logic                        captureTickClock,
	output logic                        intervalTickClock,
	output logic                        intervalIrq,
	output logic                        msIntervalTick,
	output logic      [2:0]             fastOscOffset,
	output logic      [4:0]             fastOscGain,
	output logic      [2:0]             crystalOscGm,
	output logic                        crystalOscTestMode,
	output logic                        slowOscLowPower,
	output logic      [1:0]             slowOscBias,
	output logic      [3:0]             slowOscFreqTrim
);

	typedef struct packed {
		logic [TCIT_NUM_SRC-1:0] sync1;
		logic [TCIT_NUM_SRC-1:0] sync2;
		logic [TCIT_NUM_SRC-1:0] prevSrc;
		logic [7:0]              timerCfg;
		logic                    xtalEnable;
		logic [7:0]              fastTrim;
		logic [7:0]              xtalTrim;
		logic [7:0]              slowTrim;
		logic [TCIT_CNT_W-1:0]   reload;
		logic [1:0]              capSelAct;
		logic [1:0]              capDivAct;
		logic [2:0]              capCnt;
		logic [1:0]              intSelAct;
		logic [1:0]              intDivAct;
		logic [1:0]              intCnt;
		logic [TCIT_CNT_W-1:0]   intervalCount;
		logic [11:0]             msCnt;
		logic                    captureTick;
		logic                    intervalTick;
		logic                    irq;
		logic                    msTick;
		logic [TCIT_DATA_W-1:0]  rdata;
		logic                    slverr;
	} tcit_state_t;

	tcit_state_t st;
	tcit_state_t next_st;

	logic [TCIT_NUM_SRC-1:0] srcEdges;
	logic                    extEdge;
	logic                    capEdge;
	logic                    intEdge;
	logic                    capWrap;
	logic                    intWrap;
	logic                    busWrite;
	logic                    busSetup;

	// one source edge out of the select code; code 11 means "other" for each clock
	function automatic logic pick_edge(input logic [1:0] sel,
	                                   input logic [TCIT_NUM_SRC-1:0] edges,
	                                   input logic ext,
	                                   input logic other);
		logic e;
		e = 1'b0;
		unique case (sel)
			TCIT_SRC_FAST:  e = edges[TCIT_PIN_FAST];
			TCIT_SRC_EXT:   e = ext;
			TCIT_SRC_SLOW:  e = edges[TCIT_PIN_SLOW];
			TCIT_SRC_OTHER: e = other;
		endcase
		return e;
	endfunction

	function automatic logic addr_is(input logic [TCIT_ADDR_W-1:0] a,
	                                 input logic [TCIT_ADDR_W-1:0] reg_addr);
		return a == reg_addr;
	endfunction

	assign srcEdges = st.sync2 & ~st.prevSrc;
	// crystal output while enabled, raw input pin otherwise
	assign extEdge  = st.xtalEnable ? srcEdges[TCIT_PIN_XTAL] : srcEdges[TCIT_PIN_EXT];
	// capture clock: code 11 stops it
	assign capEdge  = pick_edge(st.capSelAct, srcEdges, extEdge, 1'b0);
	// interval clock: code 11 takes the capture tick
	assign intEdge  = pick_edge(st.intSelAct, srcEdges, extEdge, st.captureTick);
	// capture divide by 2(code+1): last count is {code,1}
	assign capWrap  = capEdge && (st.capCnt == {st.capDivAct, 1'b1});
	// interval divide by code+1
	assign intWrap  = intEdge && (st.intCnt == st.intDivAct);
	assign busWrite = psel && penable && pwrite;
	assign busSetup = psel && !penable;

	always_comb begin
		next_st = st;
		next_st.captureTick  = 1'b0;
		next_st.intervalTick = 1'b0;
		next_st.irq          = 1'b0;
		next_st.msTick       = 1'b0;

		// two-stage sampling of all oscillator pins
		next_st.sync1   = {slowOscPin, crystalOscPin, extClockInputPin, fastOscPin};
		next_st.sync2   = st.sync1;
		next_st.prevSrc = st.sync2;

		// capture prescaler; new select and divider take over only at a period end,
		// which needs the old source running and leaves no shortened period
		if (capEdge) begin
			next_st.capCnt = st.capCnt + 3'h1;
		end
		if (capWrap) begin
			next_st.capCnt      = 3'h0;
			next_st.captureTick = 1'b1;
			next_st.capSelAct   = st.timerCfg[TCIT_CAP_SEL_LSB +: 2];
			next_st.capDivAct   = st.timerCfg[TCIT_CAP_DIV_LSB +: 2];
		end

		// interval prescaler, same handover policy; a stopped capture clock
		// therefore pins the interval source to it
		if (intEdge) begin
			next_st.intCnt = st.intCnt + 2'h1;
		end
		if (intWrap) begin
			next_st.intCnt       = 2'h0;
			next_st.intervalTick = 1'b1;
			next_st.intSelAct    = st.timerCfg[TCIT_INT_SEL_LSB +: 2];
			next_st.intDivAct    = st.timerCfg[TCIT_INT_DIV_LSB +: 2];
		end

		// down counter; the tick after zero is spent reloading and interrupts
		if (st.intervalTick) begin
			if (st.intervalCount == '0) begin
				next_st.intervalCount = st.reload;
				next_st.irq           = 1'b1;
			end else begin
				next_st.intervalCount = st.intervalCount - 12'h001;
			end
		end

		// 1024 us tick; scales with whatever rate the capture clock really has
		if (st.captureTick) begin
			if (st.msCnt == TCIT_MS_LAST) begin
				next_st.msCnt  = '0;
				next_st.msTick = 1'b1;
			end else begin
				next_st.msCnt = st.msCnt + 12'h001;
			end
		end

		// writes land at the access edge; reload stays writable while counting,
		// so a reload between the two byte writes picks up a mixed value
		if (busWrite) begin
			if (addr_is(paddr, TCIT_ADDR_TIMER_CFG)) begin
				next_st.timerCfg = pwdata[7:0];
			end
			if (addr_is(paddr, TCIT_ADDR_PIN_CFG)) begin
				next_st.xtalEnable = pwdata[TCIT_XTAL_EN_BIT];
			end
			if (addr_is(paddr, TCIT_ADDR_FAST_TRIM)) begin
				next_st.fastTrim = pwdata[7:0] & TCIT_FAST_TRIM_MASK;
			end
			if (addr_is(paddr, TCIT_ADDR_XTAL_TRIM)) begin
				next_st.xtalTrim = pwdata[7:0] & TCIT_XTAL_TRIM_MASK;
			end
			if (addr_is(paddr, TCIT_ADDR_SLOW_TRIM)) begin
				next_st.slowTrim = pwdata[7:0] & TCIT_SLOW_TRIM_MASK;
			end
			if (addr_is(paddr, TCIT_ADDR_RELOAD_LO)) begin
				next_st.reload[7:0] = pwdata[7:0];
			end
			if (addr_is(paddr, TCIT_ADDR_RELOAD_HI)) begin
				next_st.reload[TCIT_CNT_W-1:8] = pwdata[TCIT_RELOAD_HI_W-1:0];
			end
		end

		// read data and error are prepared in the setup cycle, shown in the access cycle
		if (busSetup) begin
			next_st.rdata  = '0;
			next_st.slverr = 1'b0;
			unique case (paddr)
				TCIT_ADDR_TIMER_CFG: next_st.rdata[7:0] = st.timerCfg;
				TCIT_ADDR_PIN_CFG:   next_st.rdata[7:0] = {4'h0, st.xtalEnable, 3'h0};
				TCIT_ADDR_FAST_TRIM: next_st.rdata[7:0] = st.fastTrim;
				TCIT_ADDR_XTAL_TRIM: next_st.rdata[7:0] = st.xtalTrim;
				TCIT_ADDR_SLOW_TRIM: next_st.rdata[7:0] = st.slowTrim;
				TCIT_ADDR_RELOAD_LO: next_st.rdata[7:0] = st.reload[7:0];
				TCIT_ADDR_RELOAD_HI: next_st.rdata[TCIT_RELOAD_HI_W-1:0] = st.reload[11:8];
				TCIT_ADDR_COUNT_LO:  next_st.rdata[7:0] = st.intervalCount[7:0];
				TCIT_ADDR_COUNT_HI:  next_st.rdata[TCIT_RELOAD_HI_W-1:0] = st.intervalCount[11:8];
				default:             next_st.slverr = 1'b1;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			st               <= '0;
			st.timerCfg      <= TCIT_TIMER_CFG_RESET;
			st.capSelAct     <= TCIT_TIMER_CFG_RESET[TCIT_CAP_SEL_LSB +: 2];
			st.capDivAct     <= TCIT_TIMER_CFG_RESET[TCIT_CAP_DIV_LSB +: 2];
			st.intSelAct     <= TCIT_TIMER_CFG_RESET[TCIT_INT_SEL_LSB +: 2];
			st.intDivAct     <= TCIT_TIMER_CFG_RESET[TCIT_INT_DIV_LSB +: 2];
			// trims have no meaningful reset; boot software loads calibration
			st.fastTrim      <= TCIT_TRIM_RESET;
			st.xtalTrim      <= TCIT_TRIM_RESET;
			st.slowTrim      <= TCIT_TRIM_RESET;
		end else begin
			st <= next_st;
		end
	end

	assign pready  = 1'b1;
	assign prdata  = st.rdata;
	assign pslverr = st.slverr && psel && penable;

	// shared pins lose their drivers while the crystal owns them
	assign sharedPinOutEnable = gpioDriveReq & {2{~st.xtalEnable}};
	assign crystalOscEnable   = st.xtalEnable;
	assign captureTickClock   = st.captureTick;
	assign intervalTickClock  = st.intervalTick;
	assign intervalIrq        = st.irq;
	assign msIntervalTick     = st.msTick;

	// trim fields go straight to the analog oscillators
	assign fastOscOffset      = st.fastTrim[TCIT_FAST_OFS_LSB +: 3];
	assign fastOscGain        = st.fastTrim[TCIT_FAST_GAIN_LSB +: 5];
	assign crystalOscGm       = st.xtalTrim[TCIT_XTAL_GM_LSB +: 3];
	assign crystalOscTestMode = st.xtalTrim[TCIT_XTAL_MODE_BIT];
	assign slowOscLowPower    = st.slowTrim[TCIT_SLOW_LP_BIT];
	assign slowOscBias        = st.slowTrim[TCIT_SLOW_BIAS_LSB +: 2];
	assign slowOscFreqTrim    = st.slowTrim[TCIT_SLOW_FREQ_LSB +: 4];

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n);

	a_reload_irq: assert property (
		(st.intervalTick && st.intervalCount == '0)
		|=> (intervalIrq && st.intervalCount == $past(st.reload)))
		else $error("reload at zero did not load value and interrupt");

	a_count_down: assert property (
		(st.intervalTick && st.intervalCount != '0)
		|=> (st.intervalCount == $past(st.intervalCount) - 12'h001 && !intervalIrq))
		else $error("interval counter did not step down by one");

	a_count_hold: assert property (
		!st.intervalTick |=> $stable(st.intervalCount))
		else $error("interval counter moved without a tick");

	a_irq_cause: assert property (
		intervalIrq |-> ($past(st.intervalTick) && $past(st.intervalCount) == '0))
		else $error("interrupt without a reload");

	a_cap_stopped: assert property (
		(st.capSelAct == TCIT_SRC_OTHER) |=> !st.captureTick)
		else $error("capture tick while capture clock disabled");

	a_cap_divider: assert property (
		st.captureTick |-> $past(st.capCnt) == {$past(st.capDivAct), 1'b1})
		else $error("capture tick not at divider end");

	a_int_divider: assert property (
		st.intervalTick |-> $past(st.intCnt) == $past(st.intDivAct))
		else $error("interval tick not at divider end");

	a_pins_free: assert property (
		st.xtalEnable |-> (sharedPinOutEnable == 2'h0))
		else $error("shared pins driven while crystal enabled");

	a_ext_route: assert property (
		(st.intSelAct == TCIT_SRC_EXT && !st.xtalEnable && intEdge)
		|-> (st.sync2[TCIT_PIN_EXT] && !st.prevSrc[TCIT_PIN_EXT]))
		else $error("external source not taken from input pin");

	a_sel_stable: assert property (
		!intWrap |=> $stable(st.intSelAct) && $stable(st.intDivAct))
		else $error("interval source changed mid period");

	a_reload_write: assert property (
		(busWrite && paddr == TCIT_ADDR_RELOAD_LO)
		|=> st.reload[7:0] == $past(pwdata[7:0]))
		else $error("reload low byte write lost");

	a_ms_tick: assert property (
		msIntervalTick |-> ($past(st.captureTick) && $past(st.msCnt) == TCIT_MS_LAST))
		else $error("1024 us tick at wrong count");

	a_ms_hold: assert property (
		!st.captureTick |=> $stable(st.msCnt))
		else $error("1024 us count moved without a capture tick");

	a_cap_hold: assert property (
		!capWrap |=> $stable(st.capSelAct) && $stable(st.capDivAct))
		else $error("capture source changed mid period");

	a_int_adopt: assert property (
		intWrap |=> (st.intSelAct == $past(st.timerCfg[TCIT_INT_SEL_LSB +: 2])
			&& st.intDivAct == $past(st.timerCfg[TCIT_INT_DIV_LSB +: 2])))
		else $error("interval setting not taken at period end");

	a_cap_adopt: assert property (
		capWrap |=> (st.capSelAct == $past(st.timerCfg[TCIT_CAP_SEL_LSB +: 2])
			&& st.capDivAct == $past(st.timerCfg[TCIT_CAP_DIV_LSB +: 2])))
		else $error("capture setting not taken at period end");

	a_int_from_cap: assert property (
		(st.intSelAct == TCIT_SRC_OTHER) |-> (intEdge == st.captureTick))
		else $error("interval clock not following the capture tick");

	a_fast_route: assert property (
		(st.intSelAct == TCIT_SRC_FAST)
		|-> (intEdge == (st.sync2[TCIT_PIN_FAST] && !st.prevSrc[TCIT_PIN_FAST])))
		else $error("interval clock not following the fast oscillator");

	a_xtal_route: assert property (
		(st.intSelAct == TCIT_SRC_EXT && st.xtalEnable)
		|-> (intEdge == (st.sync2[TCIT_PIN_XTAL] && !st.prevSrc[TCIT_PIN_XTAL])))
		else $error("external source not taken from crystal");

	a_cap_ext_route: assert property (
		(st.capSelAct == TCIT_SRC_EXT) |-> (capEdge == extEdge))
		else $error("capture clock not following the external source");

	a_trim_write: assert property (
		(busWrite && paddr == TCIT_ADDR_FAST_TRIM)
		|=> (fastOscOffset == $past(pwdata[TCIT_FAST_OFS_LSB +: 3])
			&& fastOscGain == $past(pwdata[TCIT_FAST_GAIN_LSB +: 5])))
		else $error("fast oscillator trim write lost");

	a_xtal_write: assert property (
		(busWrite && paddr == TCIT_ADDR_PIN_CFG)
		|=> (crystalOscEnable == $past(pwdata[TCIT_XTAL_EN_BIT])))
		else $error("crystal enable write lost");

	a_reload_hi: assert property (
		(busWrite && paddr == TCIT_ADDR_RELOAD_HI)
		|=> st.reload[TCIT_CNT_W-1:8] == $past(pwdata[TCIT_RELOAD_HI_W-1:0]))
		else $error("reload high bits write lost");

	c_irq:       cover property (intervalIrq);
	c_ms_tick:   cover property (msIntervalTick);
	c_src_swap:  cover property (intWrap && st.timerCfg[TCIT_INT_SEL_LSB +: 2] != st.intSelAct);
	c_xtal_on:   cover property (busWrite && paddr == TCIT_ADDR_PIN_CFG
	                            ##1 st.xtalEnable);

endmodule

// >>> verification/tcit_timer_clock_bench.sv
// self-checking bench for the timer clock block: register access over APB,
// clock selection and division, interval timer reloads and trim outputs
// assumes the oscillator pins are slow square waves made here from sys_clk
`timescale 1ns/1ns

module tcit_timer_clock_bench
	import tcit_pkg::*;
;
	logic                   sys_clk;
	logic                   arst_n;
	logic                   psel;
	logic                   penable;
	logic                   pwrite;
	logic [TCIT_ADDR_W-1:0] paddr;
	logic [TCIT_DATA_W-1:0] pwdata;
	logic [TCIT_DATA_W-1:0] prdata;
	logic                   pready;
	logic                   pslverr;
	logic                   fastOscPin;
	logic                   slowOscPin;
	logic                   crystalOscPin;
	logic                   extClockInputPin;
	logic [1:0]             gpioDriveReq;
	logic [1:0]             sharedPinOutEnable;
	logic                   crystalOscEnable;
	logic                   captureTickClock;
	logic                   intervalTickClock;
	logic                   intervalIrq;
	logic                   msIntervalTick;
	logic [2:0]             fastOscOffset;
	logic [4:0]             fastOscGain;
	logic [2:0]             crystalOscGm;
	logic                   crystalOscTestMode;
	logic                   slowOscLowPower;
	logic [1:0]             slowOscBias;
	logic [3:0]             slowOscFreqTrim;
	int                     nErrors;
	int                     checks;
	int                     cyc;
	logic                   xtalOn;

	tcit_timer_clock u_dut (
		.sys_clk(sys_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .fastOscPin(fastOscPin),
		.slowOscPin(slowOscPin), .crystalOscPin(crystalOscPin),
		.extClockInputPin(extClockInputPin), .gpioDriveReq(gpioDriveReq),
		.sharedPinOutEnable(sharedPinOutEnable), .crystalOscEnable(crystalOscEnable),
		.captureTickClock(captureTickClock), .intervalTickClock(intervalTickClock),
		.intervalIrq(intervalIrq), .msIntervalTick(msIntervalTick),
		.fastOscOffset(fastOscOffset), .fastOscGain(fastOscGain),
		.crystalOscGm(crystalOscGm), .crystalOscTestMode(crystalOscTestMode),
		.slowOscLowPower(slowOscLowPower), .slowOscBias(slowOscBias),
		.slowOscFreqTrim(slowOscFreqTrim)
	);

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	// distinct pin periods (4, 6, 8, 10 cycles) let a measured period name its source
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		fastOscPin <= 1'((cyc / 2) % 2);
		extClockInputPin <= 1'((cyc / 3) % 2);
		crystalOscPin <= 1'((cyc / 4) % 2);
		slowOscPin <= 1'((cyc / 5) % 2);
	end

	task automatic endSim();
		$display("comparisons %0d mismatches %0d", checks, nErrors);
		if (nErrors == 0 && checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			nErrors++;
			$display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
			output logic [31:0] rd, output logic err);
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge sys_clk);
		penable <= 1'b1;
		// the access phase may be stretched; the wait ends when pready is high, or at the watchdog
		do begin
			@(posedge sys_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] rd;
		logic        e;
		apb(1'b1, a, d, rd, e);
	endtask

	task automatic rdChk(input logic [7:0] a, input logic [31:0] exp, input logic expErr);
		logic [31:0] rd;
		logic        e;
		apb(1'b0, a, 32'h0, rd, e);
		check(rd, exp);
		check(32'(e), 32'(expErr));
	endtask

	function automatic logic pick(input int w);
		case (w)
			0: pick = intervalTickClock;
			1: pick = captureTickClock;
			2: pick = intervalIrq;
			default: pick = msIntervalTick;
		endcase
	endfunction

	task automatic measure(input int w, input int lim, output int p);
		int n;
		n = 0;
		p = 0;
		do begin
			@(posedge sys_clk);
			#1;
			n++;
		end while (pick(w) !== 1'b1 && n < lim);
		do begin
			@(posedge sys_clk);
			#1;
			p++;
		end while (pick(w) !== 1'b1 && p < lim);
	endtask

	// first period after a change may still run on the old setting, so it is discarded
	task automatic expectPeriod(input int w, input int exp);
		int p;
		measure(w, exp * 3 + 40, p);
		measure(w, exp * 3 + 40, p);
		check(32'(p), 32'(exp));
	endtask

	task automatic countPulses(input int w, input int span, output int cnt);
		cnt = 0;
		repeat (span) begin
			@(posedge sys_clk);
			#1;
			if (pick(w) === 1'b1) cnt++;
		end
	endtask

	function automatic int srcPer(input int s);
		case (s)
			0: srcPer = 4;
			1: srcPer = xtalOn ? 8 : 6;
			default: srcPer = 10;
		endcase
	endfunction

	initial begin
		int cnt;
		arst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		gpioDriveReq = 2'h3;
		xtalOn = 1'b0;
		repeat (20) @(posedge sys_clk);
		arst_n <= 1'b1;
		rdChk(TCIT_ADDR_TIMER_CFG, 32'h8f, 1'b0);
		rdChk(TCIT_ADDR_FAST_TRIM, 32'h00, 1'b0);
		rdChk(8'h00, 32'h0, 1'b1);
		wr(TCIT_ADDR_FAST_TRIM, 32'ha5);
		// gm 001 with every reserved bit set to see the mask; gm 111 is never written
		wr(TCIT_ADDR_XTAL_TRIM, 32'he7);
		wr(TCIT_ADDR_SLOW_TRIM, 32'hdf);
		@(posedge sys_clk);
		#1;
		check(32'(fastOscOffset), 32'h5);
		check(32'(fastOscGain), 32'h05);
		check(32'(crystalOscGm), 32'h1);
		check(32'(crystalOscTestMode), 32'h1);
		check(32'(slowOscLowPower), 32'h1);
		check(32'(slowOscBias), 32'h1);
		check(32'(slowOscFreqTrim), 32'hf);
		rdChk(TCIT_ADDR_XTAL_TRIM, 32'h05, 1'b0);
		rdChk(TCIT_ADDR_SLOW_TRIM, 32'h9f, 1'b0);
		wr(TCIT_ADDR_XTAL_TRIM, 32'h0c);
		wr(TCIT_ADDR_SLOW_TRIM, 32'h03);
		@(posedge sys_clk);
		#1;
		check(32'(crystalOscGm), 32'h3);
		check(32'(crystalOscTestMode), 32'h0);
		check(32'(slowOscLowPower), 32'h0);
		check(32'(sharedPinOutEnable), 32'h3);
		// external source first from the input pin, then from the crystal
		for (int x = 0; x < 2; x++) begin
			wr(TCIT_ADDR_PIN_CFG, 32'(x * 8));
			xtalOn = 1'(x);
			@(posedge sys_clk);
			#1;
			check(32'(crystalOscEnable), 32'(x));
			check(32'(sharedPinOutEnable), x ? 32'h0 : 32'h3);
			for (int s = 0; s < 3; s++) begin
				for (int d = 0; d < 4; d++) begin
					wr(TCIT_ADDR_TIMER_CFG, 32'(d * 4 + s));
					expectPeriod(0, srcPer(s) * (d + 1));
				end
			end
		end
		for (int s = 0; s < 3; s++) begin
			for (int d = 0; d < 4; d++) begin
				wr(TCIT_ADDR_TIMER_CFG, 32'(d * 64 + s * 16));
				expectPeriod(1, srcPer(s) * 2 * (d + 1));
			end
		end
		wr(TCIT_ADDR_TIMER_CFG, 32'h4b);
		expectPeriod(0, 4 * 4 * 3);
		wr(TCIT_ADDR_TIMER_CFG, 32'h00);
		wr(TCIT_ADDR_RELOAD_HI, 32'h0);
		wr(TCIT_ADDR_RELOAD_LO, 32'h05);
		expectPeriod(2, 6 * 4);
		// both reload parts go in just after a reload, long before the next one
		measure(2, 100, cnt);
		wr(TCIT_ADDR_RELOAD_LO, 32'h02);
		wr(TCIT_ADDR_RELOAD_HI, 32'h1);
		rdChk(TCIT_ADDR_RELOAD_LO, 32'h02, 1'b0);
		rdChk(TCIT_ADDR_RELOAD_HI, 32'h1, 1'b0);
		expectPeriod(2, 259 * 4);
		begin
			int p;
			measure(3, 40000, p);
			check(32'(p), 32'(TCIT_MS_TICKS * srcPer(0) * 2));
		end
		// once the capture clock is stopped no write can move either timer clock off it
		wr(TCIT_ADDR_TIMER_CFG, 32'h33);
		repeat (50) @(posedge sys_clk);
		wr(TCIT_ADDR_TIMER_CFG, 32'h00);
		countPulses(1, 300, cnt);
		check(32'(cnt), 32'h0);
		countPulses(0, 300, cnt);
		check(32'(cnt), 32'h0);
		// a reset in mid-run frees the timer clocks and restores the defaults
		@(posedge sys_clk);
		arst_n <= 1'b0;
		repeat (20) @(posedge sys_clk);
		arst_n <= 1'b1;
		rdChk(TCIT_ADDR_TIMER_CFG, 32'(TCIT_TIMER_CFG_RESET), 1'b0);
		expectPeriod(0, srcPer(0) * 6 * 4);
		endSim();
	end

	initial begin
		repeat (90000) @(posedge sys_clk);
		nErrors++;
		$display("watchdog expired at %0t", $time);
		endSim();
	end

endmodule
